// *** verilog/mdsc_store.sv ***
// Module descriptor store: 512 bytes behind a two-wire serial slave.
// Assumes scl_i and sda_i are already synchronous to clk_i; sda is open drain.
//
// Operation
// RULE1: 512 bytes in four 128-byte blocks
// RULE2: Byte map of parameter, maker, user areas
// RULE3: Reserved 100h-13Fh always reads 00h
// RULE4: Lower 384 bytes preloaded, upper for user
// RULE5: Reversible protection over bytes 0 to 383
// RULE6: Slave only, timed by master serial clock
// RULE7: Store reached only through serial link
// RULE8: Protected bytes unchanged, others written normally
`timescale 1ns/1ps
module mdsc_store #(
	parameter logic [7:0] IMG_SEED = 8'h5a  // Preload pattern, arbitrary
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rstn_i,
	// Serial link
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_o,
	// Status
	output logic      wp_active_o
);

	// ==================================================================
	// Elaboration check
	if (mdsc_pkg::MEM_BYTES != 4 * mdsc_pkg::BLK_BYTES) begin : g_chk
		$error("store must be four blocks");
	end

	// RULE4 preload image
	function automatic logic [7:0] img(input int i);
		logic [8:0] a;
		a = 9'(i);
		if (a >= mdsc_pkg::RSV_LO && a <= mdsc_pkg::RSV_HI) return 8'h00;
		return a[7:0] ^ IMG_SEED;
	endfunction

	// ==================================================================
	// State
	mdsc_pkg::mdsc_state_t st_q, st_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [7:0]  sh_q, sh_d;
	logic [7:0]  tx_q, tx_d;
	logic [8:0]  addr_q, addr_d;
	logic        wp_q, wp_d;
	logic        wpsel_q, wpsel_d;
	logic        oe_q, oe_d;
	logic        nack_q, nack_d;
	logic        scl_q, sda_q;
	logic        wr_stb;
	logic [7:0]  mem_q [mdsc_pkg::MEM_BYTES];

	// Link events
	wire scl_rise = scl_i & ~scl_q;
	wire scl_fall = ~scl_i & scl_q;
	wire start    = scl_i & scl_q & sda_q & ~sda_i;
	wire stop     = scl_i & scl_q & ~sda_q & sda_i;

	// RULE2 region decode
	wire rsv_hit  = (addr_q >= mdsc_pkg::RSV_LO) && (addr_q <= mdsc_pkg::RSV_HI);
	wire low_hit  = (addr_q <= mdsc_pkg::PROT_HI);
	// RULE5 protection covers only the lower 384 bytes
	wire wr_blk   = rsv_hit | (wp_q & low_hit);
	wire mem_hit  = (sh_q[7:2] == mdsc_pkg::MEM_ID);
	wire wp_hit   = (sh_q[7:1] == mdsc_pkg::WP_ID);
	wire [7:0] cur_byte = mem_q[addr_q];
	// RULE3 reserved bytes read zero
	wire [7:0] mem_rd  = rsv_hit ? 8'h00 : cur_byte;
	// RULE7 the only read path is the serial shifter
	wire [7:0] rd_byte = wpsel_q ? {7'h00, wp_q} : mem_rd;
	wire [8:0] addr_inc = addr_q + 9'h001;

	// ==================================================================
	// Next state of the serial slave
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		tx_d    = tx_q;
		addr_d  = addr_q;
		wp_d    = wp_q;
		wpsel_d = wpsel_q;
		oe_d    = oe_q;
		nack_d  = nack_q;
		wr_stb  = 1'b0;
		if (start) begin
			st_d  = mdsc_pkg::ST_DEV;
			cnt_d = 4'h0;
			oe_d  = 1'b0;
		end else if (stop) begin
			st_d = mdsc_pkg::ST_IDLE;
			oe_d = 1'b0;
		end else if (st_q != mdsc_pkg::ST_IDLE) begin
			// RULE6 all bit moves follow the master clock
			if (scl_rise) begin
				if (cnt_q < mdsc_pkg::ACK_CNT) begin
					sh_d  = {sh_q[6:0], sda_i};
					cnt_d = cnt_q + 4'h1;
				end else if (cnt_q == mdsc_pkg::END_CNT) begin
					nack_d = sda_i;
				end
			end else if (scl_fall) begin
				if (cnt_q == mdsc_pkg::ACK_CNT) begin
					cnt_d = mdsc_pkg::END_CNT;
					oe_d  = 1'b0;
					unique case (st_q)
						mdsc_pkg::ST_DEV: begin
							if (mem_hit | wp_hit) begin
								oe_d    = 1'b1;
								wpsel_d = wp_hit;
								if (mem_hit) addr_d[8] = sh_q[1];
								st_d = sh_q[0] ? mdsc_pkg::ST_RDAT : mdsc_pkg::ST_WADR;
							end else begin
								st_d = mdsc_pkg::ST_IDLE;
							end
						end
						mdsc_pkg::ST_WADR: begin
							oe_d = 1'b1;
							// RULE5 set or clear protection
							if (wpsel_q) wp_d = sh_q[0];
							else addr_d[7:0] = sh_q;
							st_d = mdsc_pkg::ST_WDAT;
						end
						mdsc_pkg::ST_WDAT: begin
							oe_d   = 1'b1;
							wr_stb = ~wpsel_q;
							if (!wpsel_q) addr_d = addr_inc;
						end
						mdsc_pkg::ST_RDAT: begin
							if (!wpsel_q) addr_d = addr_inc;
						end
					endcase
				end else if (cnt_q == mdsc_pkg::END_CNT) begin
					cnt_d = 4'h0;
					oe_d  = 1'b0;
					if (st_q == mdsc_pkg::ST_RDAT) begin
						if (nack_q) begin
							st_d = mdsc_pkg::ST_IDLE;
						end else begin
							tx_d = rd_byte;
							oe_d = ~rd_byte[7];
						end
					end
				end else if (st_q == mdsc_pkg::ST_RDAT) begin
					tx_d = {tx_q[6:0], 1'b0};
					oe_d = ~tx_q[6];
				end
			end
		end
	end

	// ==================================================================
	// Slave registers
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q    <= mdsc_pkg::ST_IDLE;
			cnt_q   <= 4'h0;
			sh_q    <= 8'h00;
			tx_q    <= 8'h00;
			addr_q  <= 9'h000;
			wp_q    <= mdsc_pkg::WP_RESET;
			wpsel_q <= 1'b0;
			oe_q    <= 1'b0;
			nack_q  <= 1'b0;
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			tx_q    <= tx_d;
			addr_q  <= addr_d;
			wp_q    <= wp_d;
			wpsel_q <= wpsel_d;
			oe_q    <= oe_d;
			nack_q  <= nack_d;
			scl_q   <= scl_i;
			sda_q   <= sda_i;
		end
	end

	// Open-drain pin only ever pulls low
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) sda_o <= 1'b0;
		else sda_o <= 1'b0;
	end

	assign sda_oe_o    = oe_q;
	assign wp_active_o = wp_q;

	// ==================================================================
	// Storage, one byte per generate entry
	// RULE1 four 128-byte blocks
	for (genvar i = 0; i < mdsc_pkg::MEM_BYTES; i++) begin : g_mem
		localparam logic [7:0] PRE = img(i);  // Reset image of this byte
		// RULE8 blocked writes leave the byte alone
		always_ff @(posedge clk_i or negedge rstn_i) begin
			if (!rstn_i) mem_q[i] <= PRE;
			else if (wr_stb && !wr_blk && addr_q == 9'(i)) mem_q[i] <= sh_q;
		end
	end

	// ==================================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence wp_cmd_s;
		scl_fall && cnt_q == mdsc_pkg::ACK_CNT && st_q == mdsc_pkg::ST_WADR && wpsel_q;
	endsequence
	sequence dev_ack_s;
		scl_fall && cnt_q == mdsc_pkg::ACK_CNT && st_q == mdsc_pkg::ST_DEV && (mem_hit || wp_hit);
	endsequence
	// Read shifter loads the next byte after a master ack
	sequence rd_load_s;
		scl_fall && cnt_q == mdsc_pkg::END_CNT && st_q == mdsc_pkg::ST_RDAT && !nack_q;
	endsequence

	addr_wrap_a: assert property (wr_stb && addr_q == mdsc_pkg::ADDR_TOP |=> addr_q == 9'h000) // RULE1
		else $error("address did not wrap at store end");
	map_read_a: assert property (rd_load_s and (!rsv_hit && !wpsel_q) |=> tx_q == mem_q[$past(addr_q)]) // RULE2
		else $error("read data not taken from store");
	reserved_zero_a: assert property (rd_load_s and (rsv_hit && !wpsel_q) |=> tx_q == 8'h00) // RULE3
		else $error("reserved byte read not zero");
	user_open_a: assert property (wr_stb && addr_q >= mdsc_pkg::USER_LO |-> !wr_blk) // RULE4
		else $error("user area write blocked");
	wp_update_a: assert property (wp_cmd_s |=> wp_q == $past(sh_q[0]) && wp_active_o == wp_q) // RULE5
		else $error("protection state not updated");
	dev_ack_a: assert property (dev_ack_s |=> sda_oe_o [*1] ##1 (sda_oe_o || !scl_q)) // RULE6
		else $error("select byte not acknowledged");
	idle_quiet_a: assert property (st_q == mdsc_pkg::ST_IDLE |-> !sda_oe_o) // RULE7
		else $error("pin driven outside a transfer");
	protect_hold_a: assert property (wr_stb && wr_blk |=> mem_q[$past(addr_q)] == $past(cur_byte)) // RULE8
		else $error("protected byte changed");
	open_write_a: assert property (wr_stb && !wr_blk |=> mem_q[$past(addr_q)] == $past(sh_q)) // RULE8
		else $error("unprotected write lost");

endmodule

// *** verilog/mdsc_pkg.sv ***
// Package for the module descriptor store: byte map, bus ids, bit counts.
// Assumes one 20 MHz clock and a two-wire serial link sampled on that clock.
package mdsc_pkg;

	// ==================================================================
	// Byte map of the store
	localparam int          MEM_BYTES = 512;
	localparam int          BLK_BYTES = 128;
	localparam int          ADDR_W    = 9;
	localparam logic [8:0]  RSV_LO    = 9'h100;  // Reserved range, reads zero
	localparam logic [8:0]  RSV_HI    = 9'h13f;
	localparam logic [8:0]  MFG_LO    = 9'h140;  // Manufacturing information
	localparam logic [8:0]  PROT_HI   = 9'h17f;  // Last byte under protection
	localparam logic [8:0]  USER_LO   = 9'h180;  // End-user area
	localparam logic [8:0]  ADDR_TOP  = 9'h1ff;

	// ==================================================================
	// Serial link ids and bit counts
	localparam logic [5:0]  MEM_ID    = 6'h28;   // Store select, bit below it is page
	localparam logic [6:0]  WP_ID     = 7'h36;   // Protection control select
	localparam logic [3:0]  ACK_CNT   = 4'h8;    // Ninth bit slot begins
	localparam logic [3:0]  END_CNT   = 4'h9;    // Ninth bit slot in progress
	localparam logic        WP_RESET  = 1'b0;    // Protection state after reset

	// ==================================================================
	// Serial clock ceiling
	localparam int          CLK_KHZ   = 20000;
	localparam int          SCL_MAX_KHZ = 1000;
	localparam int          SCL_HALF_CYC = CLK_KHZ / SCL_MAX_KHZ / 2;

	// Transfer phases, Gray coded along the write path
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DEV  = 3'h1,
		ST_WADR = 3'h3,
		ST_WDAT = 3'h2,
		ST_RDAT = 3'h6
	} mdsc_state_t;

endpackage

// *** bench/mdsc_host_model.sv ***
// Two-wire bus master model that drives the store's serial link.
// Assumes the bench resolves the open-drain data wire and feeds it back.
`timescale 1ns/1ps
module mdsc_host_model (
	// Clock and resolved data wire
	input  wire logic clk_i,
	input  wire logic sda_i,
	// Master-driven lines
	output logic      scl_o,
	output logic      sda_o
);
	// ==============================================================
	// Bus idles high, both lines released
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	task automatic half();
		repeat (mdsc_pkg::SCL_HALF_CYC) @(negedge clk_i);
	endtask

	// Start or repeated start, scl left low
	task automatic start();
		sda_o = 1'b1;
		half();
		scl_o = 1'b1;
		half();
		sda_o = 1'b0;
		half();
		scl_o = 1'b0;
	endtask

	// Stop, bus left idle
	task automatic stop();
		sda_o = 1'b0;
		half();
		scl_o = 1'b1;
		half();
		sda_o = 1'b1;
		half();
	endtask

	// One bit slot, wire sampled late in the high phase
	task automatic xbit(input logic b, output logic r);
		sda_o = b;
		half();
		scl_o = 1'b1;
		half();
		r = sda_i;
		scl_o = 1'b0;
	endtask

	// Byte MSB first, then the ninth bit
	task automatic xbyte(input logic [7:0] d, input logic ai, output logic [7:0] q,
		output logic ao);
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], q[i]);
		end
		xbit(ai, ao);
	endtask
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the descriptor store over its serial link.
// Assumes the master model in mdsc_host_model and a pulled-up data wire.
`timescale 1ns/1ps
module tb_top;
	// ==============================================================
	// Clock, reset, wires
	localparam logic [7:0] SEED = 8'h5a;  // Preload pattern, arbitrary
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic       scl;
	logic       m_sda;
	logic       sda_o;
	logic       sda_oe;
	logic       wp;
	logic [7:0] q;
	logic       a;
	int         err_count = 0;
	int         cmp_count = 0;
	int         cyc = 0;
	wire logic  sda = m_sda & ~sda_oe;

	// Clock generator
	always #25 clk = ~clk;

	mdsc_store #(.IMG_SEED(SEED)) DUT (.clk_i(clk), .rstn_i(rstn), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .wp_active_o(wp));
	mdsc_host_model m (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));

	// ==============================================================
	// Shared tasks
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic sel(input logic [8:0] ad);
		m.start();
		m.xbyte({mdsc_pkg::MEM_ID, ad[8], 1'b0}, 1'b1, q, a);
		chk({7'h0, a}, 8'h00);
		m.xbyte(ad[7:0], 1'b1, q, a);
		chk({7'h0, a}, 8'h00);
	endtask

	task automatic wr(input logic [8:0] ad, input logic [7:0] d);
		sel(ad);
		m.xbyte(d, 1'b1, q, a);
		chk({7'h0, a}, 8'h00);
		m.stop();
	endtask

	task automatic rd(input logic [8:0] ad, input logic [7:0] e);
		sel(ad);
		m.start();
		m.xbyte({mdsc_pkg::MEM_ID, ad[8], 1'b1}, 1'b1, q, a);
		m.xbyte(8'hff, 1'b1, q, a);
		m.stop();
		chk(q, e);
	endtask

	task automatic setwp(input logic v);
		m.start();
		m.xbyte({mdsc_pkg::WP_ID, 1'b0}, 1'b1, q, a);
		m.xbyte({7'h0, v}, 1'b1, q, a);
		m.stop();
		chk({7'h0, wp}, {7'h0, v});
		// Read the protection state back over the link
		m.start();
		m.xbyte({mdsc_pkg::WP_ID, 1'b1}, 1'b1, q, a);
		m.xbyte(8'hff, 1'b1, q, a);
		m.stop();
		chk(q, {7'h0, v});
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ==============================================================
	// Scenarios
	task automatic t_map();
		chk({5'h0, sda_o, wp, sda_oe}, 8'h00);
		rd(9'h000, SEED);
		rd(9'h0ff, 8'hff ^ SEED);
		rd(9'h17f, 8'h7f ^ SEED);
		rd(9'h100, 8'h00);
		rd(9'h13f, 8'h00);
		$display("done map");
	endtask

	task automatic t_write();
		wr(9'h1ff, 8'h3c);
		rd(9'h1ff, 8'h3c);
		wr(9'h120, 8'h99);
		rd(9'h120, 8'h00);
		$display("done write");
	endtask

	task automatic t_prot();
		setwp(1'b1);
		wr(9'h17f, 8'h77);
		rd(9'h17f, 8'h7f ^ SEED);
		wr(9'h180, 8'h66);
		rd(9'h180, 8'h66);
		setwp(1'b0);
		wr(9'h17f, 8'h77);
		rd(9'h17f, 8'h77);
		$display("done prot");
	endtask

	task automatic t_badid();
		m.start();
		m.xbyte(8'h20, 1'b1, q, a);
		m.stop();
		chk({7'h0, a}, 8'h01);
		$display("done badid");
	endtask

	// Timeout watchdog
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			$display("FAIL %0t timeout", $time);
			err_count++;
			conclude();
		end
	end

	// Main sequence
	initial begin
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		t_map();
		t_write();
		t_prot();
		t_badid();
		conclude();
	end
endmodule
